/* File: logic/fdc_pkg.sv */
// constants, state type and rate helper for the rate, power and reset control block
`default_nettype none
package fdc_pkg;
  // host addresses
  localparam logic [9:0] ADDR_DOR = 10'h002;
  localparam logic [9:0] ADDR_DSR = 10'h004;
  localparam logic [9:0] ADDR_DATA = 10'h005;
  localparam logic [9:0] ADDR_CCR = 10'h3F7;
  // field positions
  localparam int RATE_LSB = 0;
  localparam int PRECOMP_LSB = 2;
  localparam int DSR_LP_BIT = 6;
  localparam int DSR_RST_BIT = 7;
  localparam int DOR_RST_N_BIT = 2;
  // reset values
  localparam logic [1:0] RATE_RESET = 2'h2;
  localparam logic [2:0] PRECOMP_RESET = 3'h0;
  localparam logic [7:0] TRACK_RESET = 8'h00;
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic [7:0] DOR_RESET = 8'h04;
  localparam logic [7:0] MSR_INIT_VAL = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  // rate codes and clock dividers from the 24 MHz reference
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [7:0] DIV_500K = 8'h30;
  localparam logic [7:0] DIV_300K = 8'h50;
  localparam logic [7:0] DIV_250K = 8'h60;
  localparam logic [7:0] DIV_1M = 8'h18;
  // timing
  localparam int CLK_KHZ = 10000;
  localparam int INIT_TIME_NS = 2500;
  localparam int INIT_CYC = INIT_TIME_NS * CLK_KHZ / 1000000;
  localparam int OSC_STABLE_US = 2000;
  localparam int AUTO_LP_MS = 500;
  localparam int TMR_W = 23;

  // power and reset sequencing states
  typedef enum logic [3:0] {
    FDC_INIT = 4'b0001,
    FDC_RUN = 4'b0010,
    FDC_PDOWN = 4'b0100,
    FDC_WAKE = 4'b1000
  } fdc_state_t;

  // sequencer and separator divider for a rate code
  function automatic logic [7:0] fdc_rate_div(input logic [1:0] code);
    case (code)
      RATE_500K: fdc_rate_div = DIV_500K;
      RATE_300K: fdc_rate_div = DIV_300K;
      RATE_250K: fdc_rate_div = DIV_250K;
      default: fdc_rate_div = DIV_1M;
    endcase
  endfunction : fdc_rate_div
endpackage : fdc_pkg
`default_nettype wire

/* File: logic/fdc_timer.sv */
// down counter with load and one-cycle expiry pulse
`default_nettype none
module fdc_timer #(
  parameter int W = 23
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // status
  output logic expire
);
  import fdc_pkg::*;

  logic [W-1:0] cnt_q;

  // counts down to zero and rests there until reloaded
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
    end
    else if (load)
    begin
      cnt_q <= load_val;
    end
    else if (cnt_q != '0)
    begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  // pulse on the last count; taken from the count only, so no path runs from load to expiry
  assign expire = (cnt_q == W'(1));
endmodule : fdc_timer
`default_nettype wire

/* File: logic/fdc_rate_hold.sv */
// active rate code, precompensation value and clock divider
`default_nettype none
module fdc_rate_hold (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register writes
  input wire logic ccr_we,
  input wire logic dsr_we,
  input wire logic [7:0] wdata,
  // results
  output logic [1:0] rate_q,
  output logic [2:0] precomp_q,
  output logic [7:0] clk_div_q
);
  import fdc_pkg::*;

  // both registers share one rate field, so the later write wins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rate_q <= RATE_RESET;
      clk_div_q <= fdc_rate_div(RATE_RESET);
    end
    else if (ccr_we || dsr_we)
    begin
      rate_q <= wdata[RATE_LSB +: 2];
      clk_div_q <= fdc_rate_div(wdata[RATE_LSB +: 2]);
    end
  end

  // precompensation only comes from the rate select register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      precomp_q <= PRECOMP_RESET;
    end
    else if (dsr_we)
    begin
      precomp_q <= wdata[PRECOMP_LSB +: 3];
    end
  end
endmodule : fdc_rate_hold
`default_nettype wire

/* File: logic/fdc_ctrl_top.sv */
// rate selection, low power and reset sequencing for the floppy controller
`default_nettype none
module fdc_ctrl_top #(
  parameter int OSC_CYC = fdc_pkg::OSC_STABLE_US * fdc_pkg::CLK_KHZ / 1000,
  parameter int AUTO_LP_CYC = fdc_pkg::AUTO_LP_MS * fdc_pkg::CLK_KHZ
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host register bus
  input wire logic host_cs,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [9:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic data_rd_strobe,
  output logic data_wr_strobe,
  // command engine status
  input wire logic eng_idle,
  input wire logic eng_ready,
  input wire logic [6:0] eng_msr_bits,
  // configure command
  input wire logic cfg_we,
  input wire logic cfg_fifo_en,
  input wire logic [3:0] cfg_level,
  input wire logic [7:0] cfg_track,
  input wire logic cfg_implied_seek,
  input wire logic cfg_poll_en,
  // mode and lock commands
  input wire logic mode_we,
  input wire logic mode_manual_lp,
  input wire logic mode_auto_lp,
  input wire logic mode_fwr_in,
  input wire logic mode_frd_in,
  input wire logic mode_bst_in,
  input wire logic lock_we,
  input wire logic lock_bit,
  // settings to the command engine
  output logic core_reset,
  output logic fifo_en,
  output logic [3:0] fifo_level_setting,
  output logic [7:0] precomp_start_track,
  output logic implied_seek_en,
  output logic poll_en,
  output logic mode_fifo_write_opt,
  output logic mode_fifo_read_opt,
  output logic mode_burst_opt,
  // clocking and pins
  output logic osc_enable,
  output logic logic_halt,
  output logic rate_code_out_low,
  output logic rate_code_out_high,
  output logic [7:0] clk_div,
  output logic [2:0] precomp_sel,
  output logic [7:0] digital_output_reg
);
  import fdc_pkg::*;

  fdc_state_t st_q, st_d;
  logic [7:0] dor_q, rdata_q, track_q, div_q, main_status_reg;
  logic [3:0] level_q;
  logic [2:0] pcomp_q;
  logic [1:0] rate_q;
  logic [TMR_W-1:0] seq_val;
  logic dsr_rst_q, dsr_lp_q, mode_lp_q, auto_lp_q, lock_q, reinit_q, fifo_en_q, seek_q, poll_q;
  logic fwr_q, frd_q, bst_q, host_request_flag, dsr_we, ccr_we, dor_we, msr_rd, data_acc;
  logic soft_rst, wake_req, lp_req, idle_run, idle_expire, seq_load, seq_expire;

  // host bus decode; every decode here works in any power state
  assign dsr_we = host_cs && host_wr && (host_addr == ADDR_DSR);
  assign ccr_we = host_cs && host_wr && (host_addr == ADDR_CCR);
  assign dor_we = host_cs && host_wr && (host_addr == ADDR_DOR);
  assign msr_rd = host_cs && host_rd && (host_addr == ADDR_DSR);
  assign data_rd_strobe = host_cs && host_rd && (host_addr == ADDR_DATA);
  assign data_wr_strobe = host_cs && host_wr && (host_addr == ADDR_DATA);
  assign data_acc = data_rd_strobe || data_wr_strobe;

  // digital output register; its reset bit loads high, so no software reset until the host clears it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dor_q <= DOR_RESET;
    end
    else if (dor_we)
    begin
      dor_q <= host_wdata;
    end
  end

  // rate select reset bit lives one cycle only, so software never clears it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dsr_rst_q <= 1'b0;
    end
    else
    begin
      dsr_rst_q <= dsr_we && host_wdata[DSR_RST_BIT];
    end
  end

  // software reset from either register source
  assign soft_rst = dsr_rst_q || !dor_q[DOR_RST_N_BIT];

  // rate code, clock divider and precompensation
  fdc_rate_hold u_rate (
    .sys_clk(sys_clk),
    .rst(rst),
    .ccr_we(ccr_we),
    .dsr_we(dsr_we),
    .wdata(host_wdata),
    .rate_q(rate_q),
    .precomp_q(pcomp_q),
    .clk_div_q(div_q)
  );

  // rate pins mirror the last written rate bits
  assign rate_code_out_low = rate_q[0];
  assign rate_code_out_high = rate_q[1];
  assign clk_div = div_q;
  assign precomp_sel = pcomp_q;

  // manual low power request from the rate select register
  // a new write wins over the wake-up clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dsr_lp_q <= 1'b0;
    end
    else if (dsr_we)
    begin
      dsr_lp_q <= host_wdata[DSR_LP_BIT];
    end
    else if (st_d == FDC_WAKE && st_q == FDC_PDOWN)
    begin
      dsr_lp_q <= 1'b0;
    end
  end

  // mode command low power bits; auto enable has no other source
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_lp_q <= 1'b0;
      auto_lp_q <= 1'b0;
    end
    else if (mode_we)
    begin
      mode_lp_q <= mode_manual_lp;
      auto_lp_q <= mode_auto_lp;
    end
    else if (st_d == FDC_WAKE && st_q == FDC_PDOWN)
    begin
      mode_lp_q <= 1'b0; // manual bit would otherwise re-enter at once
    end
  end

  // lock flag survives software reset
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lock_q <= 1'b0;
    end
    else if (lock_we)
    begin
      lock_q <= lock_bit;
    end
  end

  // configure settings; software reset clears seek and sets polling, the rest unless locked
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fifo_en_q <= 1'b0;
      level_q <= LEVEL_RESET;
      track_q <= TRACK_RESET;
      seek_q <= 1'b0;
      poll_q <= 1'b1;
    end
    else if (soft_rst)
    begin
      seek_q <= 1'b0;
      poll_q <= 1'b1;
      if (!lock_q)
      begin
        fifo_en_q <= 1'b0;
        level_q <= LEVEL_RESET;
        track_q <= TRACK_RESET;
      end
    end
    else if (cfg_we)
    begin
      fifo_en_q <= cfg_fifo_en;
      level_q <= cfg_level;
      track_q <= cfg_track;
      seek_q <= cfg_implied_seek;
      poll_q <= cfg_poll_en;
    end
  end

  // mode fifo and burst options, kept across a locked software reset
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fwr_q <= 1'b0;
      frd_q <= 1'b0;
      bst_q <= 1'b0;
    end
    else if (soft_rst && !lock_q)
    begin
      fwr_q <= 1'b0;
      frd_q <= 1'b0;
      bst_q <= 1'b0;
    end
    else if (mode_we && !soft_rst)
    begin
      fwr_q <= mode_fwr_in;
      frd_q <= mode_frd_in;
      bst_q <= mode_bst_in;
    end
  end

  assign fifo_en = fifo_en_q;
  assign fifo_level_setting = level_q;
  assign precomp_start_track = track_q;
  assign implied_seek_en = seek_q;
  assign poll_en = poll_q;
  assign mode_fifo_write_opt = fwr_q;
  assign mode_fifo_read_opt = frd_q;
  assign mode_burst_opt = bst_q;

  // idle timer reloads on any break in idleness or host command traffic
  assign idle_run = (st_q == FDC_RUN) && eng_idle && auto_lp_q && !data_acc && !soft_rst;

  fdc_timer #(
    .W(TMR_W)
  ) u_idle (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(!idle_run),
    .load_val(TMR_W'(AUTO_LP_CYC)),
    .expire(idle_expire)
  );

  // manual sources, or the idle timer expiring while still idle, ask for low power
  assign lp_req = dsr_lp_q || mode_lp_q || (idle_expire && idle_run);

  // wake-up access from the host while powered down
  assign wake_req = msr_rd || data_acc;

  // next state of the power and reset sequencer
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      FDC_INIT:
        if (seq_expire && !soft_rst)
          st_d = FDC_RUN;
      FDC_RUN:
        if (soft_rst)
          st_d = FDC_INIT;
        else if (lp_req)
          st_d = FDC_PDOWN;
      FDC_PDOWN:
        if (soft_rst || wake_req)
          st_d = FDC_WAKE;
      FDC_WAKE:
        if (seq_expire)
          st_d = (reinit_q || soft_rst) ? FDC_INIT : FDC_RUN;
      default:
        st_d = FDC_INIT;
    endcase
  end

  // the pin reset always restarts the initialisation
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= FDC_INIT;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // remembers a software reset seen during power down or wake-up; the pin reset
  // sets it too, so the first initialisation run gets its timer loaded
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reinit_q <= 1'b1;
    end
    else if (soft_rst && (st_q == FDC_PDOWN || st_q == FDC_WAKE))
    begin
      reinit_q <= 1'b1;
    end
    else if (st_q == FDC_INIT)
    begin
      reinit_q <= 1'b0;
    end
  end

  // one timer serves oscillator settling and initialisation
  // held loaded while a software reset is still asserted, and loaded once after any reset
  assign seq_load = ((st_d != st_q) && (st_d == FDC_WAKE || st_d == FDC_INIT))
                    || (st_q == FDC_INIT && (soft_rst || reinit_q));
  assign seq_val = (st_d == FDC_WAKE) ? TMR_W'(OSC_CYC) : TMR_W'(INIT_CYC);

  fdc_timer #(
    .W(TMR_W)
  ) u_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(seq_load),
    .load_val(seq_val),
    .expire(seq_expire)
  );

  // oscillator stops only in power down; the clock here keeps running
  assign osc_enable = (st_q != FDC_PDOWN);
  assign logic_halt = (st_q == FDC_PDOWN) || (st_q == FDC_WAKE);
  assign core_reset = (st_q == FDC_INIT) || soft_rst;
  assign digital_output_reg = dor_q;

  // request flag only in normal running, so it reads 0 through wake-up
  assign host_request_flag = (st_q == FDC_RUN) && eng_ready && !soft_rst;

  // main status reads all zero until initialisation finishes
  assign main_status_reg = (st_q == FDC_INIT) ? MSR_INIT_VAL
                           : {host_request_flag, eng_msr_bits};

  // read data registered one cycle after the read strobe
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= RDATA_IDLE;
    end
    else if (host_cs && host_rd)
    begin
      case (host_addr)
        ADDR_DSR: rdata_q <= main_status_reg;
        ADDR_DOR: rdata_q <= dor_q;
        default: rdata_q <= RDATA_IDLE;
      endcase
    end
  end

  assign host_rdata = rdata_q;
endmodule : fdc_ctrl_top
`default_nettype wire

/* File: testbench/fdc_ctrl_assertions.sv */
// bound checker for the rate, power and reset control ports
`default_nettype none
module fdc_ctrl_chk
  import fdc_pkg::*;
#(
  parameter int OSC_CYC = 20,
  parameter int AUTO_LP_CYC = 50
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host bus
  input wire logic host_cs,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [9:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  // control outputs
  input wire logic core_reset,
  input wire logic osc_enable,
  input wire logic logic_halt,
  input wire logic rate_code_out_low,
  input wire logic rate_code_out_high,
  input wire logic [7:0] clk_div,
  input wire logic [2:0] precomp_sel,
  input wire logic [7:0] digital_output_reg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic wr_dsr, wr_ccr, rd_msr, run;
  logic [1:0] rate;
  // decoded bus events; run excludes init, wake and held reset
  assign wr_dsr = host_cs && host_wr && host_addr == ADDR_DSR;
  assign wr_ccr = host_cs && host_wr && host_addr == ADDR_CCR;
  assign rd_msr = host_cs && host_rd && host_addr == ADDR_DSR;
  assign run = osc_enable && !logic_halt && !core_reset;
  assign rate = {rate_code_out_high, rate_code_out_low};

  property p_dsr_rate; wr_dsr |=> rate == $past(host_wdata[1:0]); endproperty
  a_dsr_rate: assert property (p_dsr_rate) else $error("rate select write lost");
  property p_ccr_rate; wr_ccr |=> rate == $past(host_wdata[1:0]); endproperty
  a_ccr_rate: assert property (p_ccr_rate) else $error("config write lost");
  property p_div; clk_div == (rate == 2'h0 ? DIV_500K : rate == 2'h1 ? DIV_300K :
    rate == 2'h2 ? DIV_250K : DIV_1M); endproperty
  a_div: assert property (p_div) else $error("divider does not match rate");
  property p_precomp; wr_dsr |=> precomp_sel == $past(host_wdata[4:2]); endproperty
  a_precomp: assert property (p_precomp) else $error("precomp not taken");
  property p_lp_enter; wr_dsr && host_wdata[6] && !host_wdata[7] && run |-> ##[1:3] !osc_enable;
  endproperty
  a_lp_enter: assert property (p_lp_enter) else $error("low power not entered");
  property p_halt; !osc_enable |-> logic_halt; endproperty
  a_halt: assert property (p_halt) else $error("logic runs without oscillator");
  property p_flag; rd_msr && logic_halt |=> !host_rdata[7]; endproperty
  a_flag: assert property (p_flag) else $error("request flag set while halted");
  property p_wake; rd_msr && !osc_enable |-> ##[1:3] osc_enable; endproperty
  a_wake: assert property (p_wake) else $error("status read did not wake");
  property p_settle; $rose(osc_enable) |-> logic_halt [*8] ##[1:40] !logic_halt; endproperty
  a_settle: assert property (p_settle) else $error("wake settling wrong");
  property p_dsr_rst; wr_dsr && host_wdata[7] && run |=> core_reset [*8] ##[1:40] !core_reset;
  endproperty
  a_dsr_rst: assert property (p_dsr_rst) else $error("reset bit not self clearing");
  property p_dor_rst; !digital_output_reg[DOR_RST_N_BIT] |-> core_reset; endproperty
  a_dor_rst: assert property (p_dor_rst) else $error("output reg reset not held");
  property p_dor_wr; host_cs && host_wr && host_addr == ADDR_DOR |=>
    digital_output_reg == $past(host_wdata); endproperty
  a_dor_wr: assert property (p_dor_wr) else $error("output reg write lost");

  // main scenarios reached
  c_lp: cover property (!osc_enable);
  c_wake: cover property ($rose(osc_enable));
  c_srst: cover property (run ##1 core_reset);
endmodule : fdc_ctrl_chk

bind fdc_ctrl_top fdc_ctrl_chk #(.OSC_CYC(OSC_CYC), .AUTO_LP_CYC(AUTO_LP_CYC)) u_chk (
  .sys_clk, .rst, .host_cs, .host_rd, .host_wr, .host_addr, .host_wdata, .host_rdata,
  .core_reset, .osc_enable, .logic_halt, .rate_code_out_low, .rate_code_out_high,
  .clk_div, .precomp_sel, .digital_output_reg
);
`default_nettype wire

/* File: testbench/fdc_host_model.sv */
// host processor model driving the register bus of the control block
`default_nettype none
module fdc_host_model (
  // clock
  input wire logic sys_clk,
  // register bus
  output logic host_cs,
  output logic host_rd,
  output logic host_wr,
  output logic [9:0] host_addr,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus; released lines get inverted values so nothing leans on stale ones
  initial
  begin
    {host_cs, host_rd, host_wr} = 3'h0;
    host_addr = 10'h155;
    host_wdata = 8'hAA;
  end
  // one-cycle write, raised after a falling edge, held over the sampling edge
  task automatic bus_wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {host_cs, host_wr, host_addr, host_wdata} = {2'h3, a, d};
    @(negedge sys_clk);
    {host_cs, host_wr, host_addr, host_wdata} = {2'h0, ~a, ~d};
  endtask : bus_wr
  // one-cycle read, data registered at the sampling edge
  task automatic bus_rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    {host_cs, host_rd, host_addr} = {2'h3, a};
    @(negedge sys_clk);
    d = host_rdata;
    {host_cs, host_rd, host_addr} = {2'h0, ~a};
  endtask : bus_rd
endmodule : fdc_host_model
`default_nettype wire

/* File: testbench/fdc_rate_power_reset_ctrl_test.sv */
// self-checking bench for the rate, power and reset control block
`default_nettype none
`define FDC_CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value %s exp %0h got %0h", nm, (exp), (got)); end end
module fdc_rate_power_reset_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import fdc_pkg::*;
  localparam logic [3:0][7:0] DIVS = {DIV_1M, DIV_250K, DIV_300K, DIV_500K};
  int bad_count = 0;
  int n_compared = 0;
  int n_data = 0;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic host_cs, host_rd, host_wr, eng_idle, eng_ready, cfg_we, cfg_fifo_en;
  logic cfg_implied_seek, cfg_poll_en, mode_we, mode_manual_lp, mode_auto_lp;
  logic mode_fwr_in, mode_frd_in, mode_bst_in, lock_we, lock_bit, data_rd_strobe;
  logic data_wr_strobe, core_reset, fifo_en, implied_seek_en, poll_en, mode_fifo_write_opt;
  logic mode_fifo_read_opt, mode_burst_opt, osc_enable, logic_halt;
  logic rate_code_out_low, rate_code_out_high;
  logic [9:0] host_addr;
  logic [7:0] host_wdata, host_rdata, cfg_track, precomp_start_track, clk_div;
  logic [7:0] digital_output_reg;
  logic [6:0] eng_msr_bits;
  logic [3:0] cfg_level, fifo_level_setting;
  logic [2:0] precomp_sel;
  logic [1:0] rate_now;
  logic [14:0] cfg_now;
  logic [2:0] mode_now;
  assign rate_now = {rate_code_out_high, rate_code_out_low};
  assign cfg_now = {fifo_en, fifo_level_setting, precomp_start_track, implied_seek_en, poll_en};
  assign mode_now = {mode_fifo_write_opt, mode_fifo_read_opt, mode_burst_opt};
  // counts cycles in which the data register strobes reach the engine
  always @(posedge sys_clk)
    if (data_wr_strobe === 1'b1 || data_rd_strobe === 1'b1)
      n_data++;

  // clock keeps running through low power, as the system must allow
  always #50 sys_clk = ~sys_clk;

  fdc_host_model u_host (.sys_clk, .host_cs, .host_rd, .host_wr, .host_addr, .host_wdata,
    .host_rdata);
  // short settle and idle counts keep the run brief
  fdc_ctrl_top #(.OSC_CYC(20), .AUTO_LP_CYC(50)) uut (
    .sys_clk, .rst, .host_cs, .host_rd, .host_wr, .host_addr, .host_wdata, .host_rdata,
    .data_rd_strobe, .data_wr_strobe, .eng_idle, .eng_ready, .eng_msr_bits, .cfg_we,
    .cfg_fifo_en, .cfg_level, .cfg_track, .cfg_implied_seek, .cfg_poll_en, .mode_we,
    .mode_manual_lp, .mode_auto_lp, .mode_fwr_in, .mode_frd_in, .mode_bst_in, .lock_we,
    .lock_bit, .core_reset, .fifo_en, .fifo_level_setting, .precomp_start_track,
    .implied_seek_en, .poll_en, .mode_fifo_write_opt, .mode_fifo_read_opt, .mode_burst_opt,
    .osc_enable, .logic_halt, .rate_code_out_low, .rate_code_out_high, .clk_div,
    .precomp_sel, .digital_output_reg
  );

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // bounded wait on oscillator enable (0) or core reset (1)
  task automatic wait_lvl(input bit which, input logic val, input int lim);
    int k;
    k = 0;
    while ((which ? core_reset : osc_enable) !== val && k < lim)
    begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= lim)
    begin
      bad_count++;
      $display("wrong value wait exp %0h got timeout", val);
      summarize();
    end
  endtask : wait_lvl
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.bus_rd(a, d);
    `FDC_CHK("rdata", e, d)
  endtask : rd_chk
  // one-cycle configure, mode and lock command pulses
  task automatic cmd(input logic [2:0] we, input logic [14:0] v);
    @(negedge sys_clk);
    {cfg_fifo_en, cfg_level, cfg_track, cfg_implied_seek, cfg_poll_en} = v;
    {mode_manual_lp, mode_auto_lp, mode_fwr_in, mode_frd_in, mode_bst_in} = v[4:0];
    lock_bit = v[0];
    {cfg_we, mode_we, lock_we} = we;
    @(negedge sys_clk);
    {cfg_we, mode_we, lock_we} = 3'h0;
  endtask : cmd
  task automatic chk_dflt;
    `FDC_CHK("rate", RATE_RESET, rate_now)
    `FDC_CHK("div", DIV_250K, clk_div)
    `FDC_CHK("precomp", 3'h0, precomp_sel)
    `FDC_CHK("dor", 8'h04, digital_output_reg)
    `FDC_CHK("cfg", 15'h0001, cfg_now)
    `FDC_CHK("mode", 3'h0, mode_now)
  endtask : chk_dflt

  initial
  begin
    #1000000;
    bad_count++;
    summarize();
  end

  initial
  begin
    {eng_idle, eng_ready, eng_msr_bits, cfg_we, mode_we, lock_we, lock_bit} = 13'h0;
    {cfg_fifo_en, cfg_level, cfg_track, cfg_implied_seek, cfg_poll_en} = 15'h0;
    {mode_manual_lp, mode_auto_lp, mode_fwr_in, mode_frd_in, mode_bst_in} = 5'h0;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    chk_dflt();
    rd_chk(ADDR_DSR, 8'h00);
    u_host.bus_wr(ADDR_DOR, 8'h0C);
    rd_chk(ADDR_DOR, 8'h0C);
    eng_ready = 1'b1;
    wait_lvl(1, 1'b0, 40);
    rd_chk(ADDR_DSR, 8'h80);
    $display("test reset done");
    // rate codes through both registers, each overriding the other
    for (int i = 0; i < 4; i++)
    begin
      u_host.bus_wr(ADDR_DSR, {3'h0, 3'(i + 3), 2'(i)});
      `FDC_CHK("rate", 2'(i), rate_now)
      `FDC_CHK("precomp", 3'(i + 3), precomp_sel)
      u_host.bus_wr(ADDR_CCR, {6'h0, 2'(3 - i)});
      `FDC_CHK("rate", 2'(3 - i), rate_now)
      `FDC_CHK("div", DIVS[3 - i], clk_div)
    end
    rd_chk(ADDR_CCR, 8'h00);
    $display("test rate done");
    cmd(3'b100, {1'b1, 4'h5, 8'h09, 1'b1, 1'b0});
    `FDC_CHK("cfg", {1'b1, 4'h5, 8'h09, 1'b1, 1'b0}, cfg_now)
    cmd(3'b010, 15'h0007);
    // motor and selects off before low power is host duty
    u_host.bus_wr(ADDR_DOR, 8'h04);
    u_host.bus_wr(ADDR_DSR, 8'h41);
    wait_lvl(0, 1'b0, 5);
    u_host.bus_wr(ADDR_CCR, 8'h02);
    `FDC_CHK("rate", 2'h2, rate_now)
    rd_chk(ADDR_DOR, 8'h04);
    rd_chk(ADDR_DSR, 8'h00);
    wait_lvl(0, 1'b1, 3);
    rd_chk(ADDR_DSR, 8'h00);
    repeat (30) @(negedge sys_clk);
    rd_chk(ADDR_DSR, 8'h80);
    `FDC_CHK("cfg", {1'b1, 4'h5, 8'h09, 1'b1, 1'b0}, cfg_now)
    repeat (10) @(negedge sys_clk);
    `FDC_CHK("osc", 1'b1, osc_enable)
    cmd(3'b010, 15'h0017);
    wait_lvl(0, 1'b0, 5);
    u_host.bus_wr(ADDR_DATA, 8'h00);
    `FDC_CHK("data strobe", 1, n_data)
    wait_lvl(0, 1'b1, 3);
    repeat (30) @(negedge sys_clk);
    `FDC_CHK("osc", 1'b1, osc_enable)
    $display("test manual low power done");
    cmd(3'b010, 15'h000F);
    eng_idle = 1'b1;
    repeat (30) @(negedge sys_clk);
    eng_idle = 1'b0;
    @(negedge sys_clk);
    eng_idle = 1'b1;
    repeat (45) @(negedge sys_clk);
    `FDC_CHK("osc", 1'b1, osc_enable)
    wait_lvl(0, 1'b0, 20);
    rd_chk(ADDR_DSR, 8'h00);
    repeat (25) @(negedge sys_clk);
    wait_lvl(0, 1'b0, 80);
    eng_idle = 1'b0;
    rd_chk(ADDR_DSR, 8'h00);
    repeat (25) @(negedge sys_clk);
    $display("test auto low power done");
    u_host.bus_wr(ADDR_DSR, 8'h82);
    wait_lvl(1, 1'b1, 3);
    wait_lvl(1, 1'b0, 40);
    `FDC_CHK("cfg", 15'h0001, cfg_now)
    `FDC_CHK("mode", 3'h0, mode_now)
    cmd(3'b101, {1'b1, 4'h5, 8'h09, 1'b1, 1'b1});
    cmd(3'b010, 15'h0007);
    u_host.bus_wr(ADDR_DOR, 8'h00);
    repeat (40) @(negedge sys_clk);
    `FDC_CHK("core reset", 1'b1, core_reset)
    rd_chk(ADDR_DOR, 8'h00);
    rd_chk(ADDR_DSR, 8'h00);
    u_host.bus_wr(ADDR_DOR, 8'h04);
    wait_lvl(1, 1'b0, 40);
    `FDC_CHK("cfg", {1'b1, 4'h5, 8'h09, 1'b0, 1'b1}, cfg_now)
    `FDC_CHK("mode", 3'h7, mode_now)
    rd_chk(ADDR_DSR, 8'h80);
    $display("test soft reset done");
    u_host.bus_wr(ADDR_DSR, 8'h40);
    wait_lvl(0, 1'b0, 5);
    u_host.bus_wr(ADDR_DSR, 8'h80);
    wait_lvl(0, 1'b1, 5);
    repeat (60) @(negedge sys_clk);
    rd_chk(ADDR_DSR, 8'h80);
    eng_msr_bits = 7'h15;
    rd_chk(ADDR_DSR, 8'h95);
    rst = 1'b1;
    @(negedge sys_clk);
    chk_dflt();
    rst = 1'b0;
    $display("test wake and hard reset done");
    summarize();
  end
endmodule : fdc_rate_power_reset_ctrl_test
`default_nettype wire
